// >>> hw/dfs_pkg.sv
// Package for the data flash sequencer: register map, commands, states,
// status codes and timing counts.
// Assumes a 100 MHz ref_clk and a plain address/strobe register port.
package dfs_pkg;
   localparam int          ADDR_W          = 20;
   localparam int          DF_ADDR_W       = 11;
   localparam int          BLK_W           = 10;
   localparam int          DF_BYTES        = 2048;
   localparam int          DF_BLOCKS       = 2;
   localparam int          BLK_BYTES       = 1024;
   localparam logic [10:0] MAX_LEN         = 11'h0_400;
   localparam logic [7:0]  ERASED_VAL      = 8'h0_0FF;
   // Register byte addresses
   localparam logic [19:0] OFS_ACCESS_CTRL = 20'hF_0090;
   localparam logic [19:0] OFS_CMD         = 20'hF_0094;
   localparam logic [19:0] OFS_ADDR_LO     = 20'hF_0098;
   localparam logic [19:0] OFS_ADDR_HI     = 20'hF_009C;
   localparam logic [19:0] OFS_LEN_LO      = 20'hF_00A0;
   localparam logic [19:0] OFS_LEN_HI      = 20'hF_00A4;
   localparam logic [19:0] OFS_WDATA       = 20'hF_00A8;
   localparam logic [19:0] OFS_STATUS      = 20'hF_00AC;
   localparam logic [19:0] OFS_RDATA       = 20'hF_00B0;
   localparam logic [19:0] OFS_CPU_FREQ    = 20'hF_00B4;
   localparam logic [19:0] OFS_MODE        = 20'hF_00B8;
   localparam logic [7:0]  RST_ACCESS_CTRL = 8'h0_000;
   localparam logic [7:0]  RST_CPU_FREQ    = 8'h0_020;
   localparam int          BIT_ACC_EN      = 0;
   localparam int          BIT_WIDE_MODE   = 0;
   // Timing: cycles per byte or per erase step, before the cpu freq offset
   localparam int          ERASE_NS        = 100;
   localparam int          STEP_NS         = 10;
   localparam logic [15:0] ERASE_CYC       = 16'(ERASE_NS / 10);
   localparam logic [15:0] STEP_CYC        = 16'((STEP_NS + 9) / 10);

   typedef enum logic [2:0] {
      DFS_CMD_NONE  = 3'b000,
      DFS_CMD_BLANK = 3'b001,
      DFS_CMD_ERASE = 3'b010,
      DFS_CMD_WRITE = 3'b011,
      DFS_CMD_VERIFY= 3'b100,
      DFS_CMD_READ  = 3'b101
   } dfs_cmd_e;

   typedef enum logic [1:0] {
      DFS_ST_BUSY   = 2'b00,
      DFS_ST_OK     = 2'b01,
      DFS_ST_ERR    = 2'b10,
      DFS_ST_BLANKE = 2'b11
   } dfs_status_e;

   typedef enum logic [2:0] {
      DFS_IDLE     = 3'b000,
      DFS_RUN      = 3'b001,
      DFS_WAIT_TRG = 3'b010,
      DFS_DONE     = 3'b011
   } dfs_state_e;
endpackage

// >>> hw/dfs_array.sv
// Data flash cell array model: byte memory with a per-byte programmed marker and a tied-off weak flag.
// Assumes the sequencer is its only user; one access per cycle.
`timescale 1ns/10ps
`default_nettype none
module dfs_array (
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   input  wire logic [10:0] addr,
   input  wire logic        wr_en,
   input  wire logic [7:0]  wr_data,
   input  wire logic        er_en,
   input  wire logic        er_blk,
   output logic      [7:0]  rd_data,
   output logic             rd_prog,
   output logic             rd_weak
);
   logic [7:0] mem_reg  [dfs_pkg::DF_BYTES];
   logic       prog_reg [dfs_pkg::DF_BYTES];
   // Cells stay unprogrammed after reset, as a blank part would
   always_ff @(posedge ref_clk) begin
      for (int i = 0; i < dfs_pkg::DF_BYTES; i++) begin
         if (!rst_n || (er_en && (i / dfs_pkg::BLK_BYTES) == int'(er_blk)))
         begin
            mem_reg[i]  <= dfs_pkg::ERASED_VAL;
            prog_reg[i] <= 1'b0;
         end else if (wr_en && i == int'(addr)) begin
            mem_reg[i]  <= wr_data;
            prog_reg[i] <= 1'b1;
         end
      end
   end
   assign rd_data = mem_reg[addr];
   assign rd_prog = prog_reg[addr];
   // Signal level always adequate here; kept as a hook for fault models
   assign rd_weak = 1'b0;
endmodule // dfs_array
`default_nettype wire

// >>> hw/dfs_seq.sv
// Data flash sequencer: access control register, command registers and
// the background engine that runs blank check, erase, write and verify.
// Assumes a single-cycle register master on the same clock.
// Contract
// - Erase clears one whole one-kilobyte block
// - Blank check spans 1..1024 bytes, one block
// - Write spans 1..1024 bytes, one block
// - Verify checks cell level, not data
// - Read completes at once, no polling
// - Dedicated engine runs rewrites in background
// - Array unreadable while rewrite runs
// - Request returns at once; poll status
// - Frequency value only scales internal timing
// - Access register eight bits, reset zero
// - Enable zero blocks array access
// - Enable one permits array access
// - Write one byte per status poll
// - Addresses relative to data flash start
//
// The strobed register port was decided locally.
`timescale 1ns/10ps
`default_nettype none
module dfs_seq (
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   input  wire logic [19:0] reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [7:0]  reg_rdata,
   output logic             seq_busy,
   output logic             osc_request
);
   dfs_pkg::dfs_state_e  state_reg, state_next;
   dfs_pkg::dfs_status_e status_reg, status_next;
   dfs_pkg::dfs_cmd_e    cmd_reg, cmd_next;
   logic [7:0]  acc_reg, acc_next;
   logic [7:0]  freq_reg, freq_next;
   logic        wide_reg, wide_next;
   logic [10:0] addr_reg, addr_next;
   logic [10:0] len_reg, len_next;
   logic [7:0]  wdata_reg, wdata_next;
   logic [7:0]  rdata_reg, rdata_next;
   logic [7:0]  out_reg, out_next;
   logic [15:0] tmr_reg, tmr_next;
   logic [10:0] a_addr;
   logic        a_wr, a_er, a_prog, a_weak;
   logic [7:0]  a_rdata;

   // Range check shared by all byte-range commands
   function automatic logic range_ok(input logic [10:0] a,
                                     input logic [10:0] n);
      logic [11:0] last;
      last = {1'b0, a} + {1'b0, n} - 12'h0_001;
      return (n != 11'h0_000) && (n <= dfs_pkg::MAX_LEN) &&
             (last[11:10] == {1'b0, a[10]});
   endfunction

   // Cycles per step; freq[7:4] is added to it, then wide voltage doubles the step
   function automatic logic [15:0] step_len(input logic [15:0] base,
                                            input logic [7:0] f,
                                            input logic w);
      logic [15:0] t;
      t = base + {12'h0_000, f[7:4]};
      return w ? {t[14:0], 1'b0} : t;
   endfunction

   dfs_array u_array (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .addr    (a_addr),
      .wr_en   (a_wr),
      .wr_data (wdata_reg),
      .er_en   (a_er),
      .er_blk  (addr_reg[10]),
      .rd_data (a_rdata),
      .rd_prog (a_prog),
      .rd_weak (a_weak)
   );

   logic enabled;
   logic wr_hit_cmd, rd_hit_status;
   assign enabled       = acc_reg[dfs_pkg::BIT_ACC_EN];
   assign wr_hit_cmd    = reg_wr && reg_addr == dfs_pkg::OFS_CMD;
   assign rd_hit_status = reg_rd && reg_addr == dfs_pkg::OFS_STATUS;
   assign a_addr        = addr_reg;
   assign seq_busy      = state_reg != dfs_pkg::DFS_IDLE &&
                          state_reg != dfs_pkg::DFS_DONE;
   assign osc_request   = enabled;

   always_comb begin
      state_next  = state_reg;
      status_next = status_reg;
      cmd_next    = cmd_reg;
      acc_next    = acc_reg;
      freq_next   = freq_reg;
      wide_next   = wide_reg;
      addr_next   = addr_reg;
      len_next    = len_reg;
      wdata_next  = wdata_reg;
      rdata_next  = rdata_reg;
      tmr_next    = tmr_reg;
      a_wr        = 1'b0;
      a_er        = 1'b0;
      // Parameter registers are frozen while the engine runs, except WDATA in DFS_WAIT_TRG
      if (reg_wr && !seq_busy) begin
         if (reg_addr == dfs_pkg::OFS_ACCESS_CTRL) begin
            acc_next = {7'h0_0, reg_wdata[dfs_pkg::BIT_ACC_EN]};
         end else if (reg_addr == dfs_pkg::OFS_ADDR_LO) begin
            addr_next = {addr_reg[10:8], reg_wdata};
         end else if (reg_addr == dfs_pkg::OFS_ADDR_HI) begin
            addr_next = {reg_wdata[2:0], addr_reg[7:0]};
         end else if (reg_addr == dfs_pkg::OFS_LEN_LO) begin
            len_next = {len_reg[10:8], reg_wdata};
         end else if (reg_addr == dfs_pkg::OFS_LEN_HI) begin
            len_next = {reg_wdata[2:0], len_reg[7:0]};
         end else if (reg_addr == dfs_pkg::OFS_WDATA) begin
            wdata_next = reg_wdata;
         end else if (reg_addr == dfs_pkg::OFS_CPU_FREQ) begin
            freq_next = reg_wdata;
         end else if (reg_addr == dfs_pkg::OFS_MODE) begin
            wide_next = reg_wdata[dfs_pkg::BIT_WIDE_MODE];
         end
      end
      case (state_reg)
         dfs_pkg::DFS_IDLE, dfs_pkg::DFS_DONE: begin
            if (wr_hit_cmd) begin
               cmd_next = dfs_pkg::dfs_cmd_e'(reg_wdata[2:0]);
               if (!enabled) begin
                  status_next = dfs_pkg::DFS_ST_ERR;
                  state_next  = dfs_pkg::DFS_DONE;
               end else if (reg_wdata[2:0] == dfs_pkg::DFS_CMD_ERASE) begin
                  status_next = dfs_pkg::DFS_ST_BUSY;
                  tmr_next    = step_len(dfs_pkg::ERASE_CYC, freq_reg,
                                         wide_reg);
                  state_next  = dfs_pkg::DFS_RUN;
               end else if (reg_wdata[2:0] == dfs_pkg::DFS_CMD_READ &&
                            range_ok(addr_reg, len_reg)) begin
                  rdata_next  = a_rdata;
                  addr_next   = addr_reg + 11'h0_001;
                  len_next    = len_reg - 11'h0_001;
                  status_next = dfs_pkg::DFS_ST_OK;
                  state_next  = dfs_pkg::DFS_DONE;
               end else if ((reg_wdata[2:0] == dfs_pkg::DFS_CMD_BLANK ||
                             reg_wdata[2:0] == dfs_pkg::DFS_CMD_WRITE ||
                             reg_wdata[2:0] == dfs_pkg::DFS_CMD_VERIFY) &&
                            range_ok(addr_reg, len_reg)) begin
                  status_next = dfs_pkg::DFS_ST_BUSY;
                  tmr_next    = step_len(dfs_pkg::STEP_CYC, freq_reg,
                                         wide_reg);
                  state_next  = dfs_pkg::DFS_RUN;
               end else begin
                  status_next = dfs_pkg::DFS_ST_ERR;
                  state_next  = dfs_pkg::DFS_DONE;
               end
            end
         end
         dfs_pkg::DFS_RUN: begin
            if (tmr_reg != 16'h0_000) begin
               tmr_next = tmr_reg - 16'h0_001;
            end else if (cmd_reg == dfs_pkg::DFS_CMD_ERASE) begin
               a_er        = 1'b1;
               status_next = dfs_pkg::DFS_ST_OK;
               state_next  = dfs_pkg::DFS_DONE;
            end else begin
               tmr_next  = step_len(dfs_pkg::STEP_CYC, freq_reg, wide_reg);
               addr_next = addr_reg + 11'h0_001;
               len_next  = len_reg - 11'h0_001;
               if (cmd_reg == dfs_pkg::DFS_CMD_BLANK && a_prog) begin
                  status_next = dfs_pkg::DFS_ST_BLANKE;
                  state_next  = dfs_pkg::DFS_DONE;
               end else if (cmd_reg == dfs_pkg::DFS_CMD_VERIFY && a_weak) begin
                  status_next = dfs_pkg::DFS_ST_ERR;
                  state_next  = dfs_pkg::DFS_DONE;
               end else if (cmd_reg == dfs_pkg::DFS_CMD_WRITE && a_prog) begin
                  status_next = dfs_pkg::DFS_ST_ERR;
                  state_next  = dfs_pkg::DFS_DONE;
               end else if (cmd_reg == dfs_pkg::DFS_CMD_WRITE) begin
                  a_wr = 1'b1;
                  if (len_reg == 11'h0_001) begin
                     status_next = dfs_pkg::DFS_ST_OK;
                     state_next  = dfs_pkg::DFS_DONE;
                  end else begin
                     state_next = dfs_pkg::DFS_WAIT_TRG;
                  end
               end else if (len_reg == 11'h0_001) begin
                  status_next = dfs_pkg::DFS_ST_OK;
                  state_next  = dfs_pkg::DFS_DONE;
               end
            end
         end
         dfs_pkg::DFS_WAIT_TRG: begin
            // Next byte data must be loaded before the poll that starts it
            if (rd_hit_status) begin
               state_next = dfs_pkg::DFS_RUN;
            end else if (reg_wr && reg_addr == dfs_pkg::OFS_WDATA) begin
               wdata_next = reg_wdata;
            end
         end
         default: begin
            state_next = dfs_pkg::DFS_IDLE;
         end
      endcase
   end

   always_comb begin
      out_next = 8'h0_000;
      if (reg_rd) begin
         if (reg_addr == dfs_pkg::OFS_ACCESS_CTRL) begin
            out_next = acc_reg;
         end else if (reg_addr == dfs_pkg::OFS_STATUS) begin
            out_next = {5'h0_0, seq_busy, status_reg};
         end else if (reg_addr == dfs_pkg::OFS_RDATA) begin
            out_next = (enabled && !seq_busy) ? rdata_reg : 8'h0_000;
         end else if (reg_addr == dfs_pkg::OFS_CPU_FREQ) begin
            out_next = freq_reg;
         end else if (reg_addr == dfs_pkg::OFS_MODE) begin
            out_next = {7'h0_0, wide_reg};
         end else if (reg_addr == dfs_pkg::OFS_CMD) begin
            out_next = {5'h0_0, cmd_reg};
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         state_reg  <= dfs_pkg::DFS_IDLE;
         status_reg <= dfs_pkg::DFS_ST_OK;
         cmd_reg    <= dfs_pkg::DFS_CMD_NONE;
         acc_reg    <= dfs_pkg::RST_ACCESS_CTRL;
         freq_reg   <= dfs_pkg::RST_CPU_FREQ;
         wide_reg   <= 1'b0;
         addr_reg   <= 11'h0_000;
         len_reg    <= 11'h0_000;
         wdata_reg  <= 8'h0_000;
         rdata_reg  <= 8'h0_000;
         out_reg    <= 8'h0_000;
         tmr_reg    <= 16'h0_000;
      end else begin
         state_reg  <= state_next;
         status_reg <= status_next;
         cmd_reg    <= cmd_next;
         acc_reg    <= acc_next;
         freq_reg   <= freq_next;
         wide_reg   <= wide_next;
         addr_reg   <= addr_next;
         len_reg    <= len_next;
         wdata_reg  <= wdata_next;
         rdata_reg  <= rdata_next;
         out_reg    <= out_next;
         tmr_reg    <= tmr_next;
      end
   end
   assign reg_rdata = out_reg;

   a_acc_reset_zero: assert property (@(posedge ref_clk)
      $rose(rst_n) |-> acc_reg == 8'h0_000)
      else $error("access register not zero after reset");
   a_acc_high_bits: assert property (@(posedge ref_clk) disable iff (!rst_n)
      acc_reg[7:1] == 7'h0_0)
      else $error("access register upper bits set");
   a_disabled_error: assert property (@(posedge ref_clk)
      disable iff (!rst_n) wr_hit_cmd && !enabled && !seq_busy
      |=> status_reg == dfs_pkg::DFS_ST_ERR && !seq_busy)
      else $error("request while disabled not refused");
   a_no_array_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !enabled |-> !a_wr && !a_er)
      else $error("array touched while disabled");
   a_read_instant: assert property (@(posedge ref_clk)
      disable iff (!rst_n) wr_hit_cmd && enabled && !seq_busy &&
      reg_wdata[2:0] == dfs_pkg::DFS_CMD_READ |=> !seq_busy)
      else $error("read entered background phase");
   a_busy_status: assert property (@(posedge ref_clk) disable iff (!rst_n)
      seq_busy |-> status_reg == dfs_pkg::DFS_ST_BUSY)
      else $error("busy without busy status");
   a_write_wait: assert property (@(posedge ref_clk)
      disable iff (!rst_n) state_reg == dfs_pkg::DFS_WAIT_TRG && !reg_rd
      |=> state_reg == dfs_pkg::DFS_WAIT_TRG)
      else $error("write step started without poll");
   a_erase_done: assert property (@(posedge ref_clk) disable iff (!rst_n)
      a_er |=> status_reg == dfs_pkg::DFS_ST_OK && !seq_busy)
      else $error("erase did not complete");
   a_one_byte: assert property (@(posedge ref_clk) disable iff (!rst_n)
      a_wr |=> !a_wr)
      else $error("two bytes written back to back");
   a_read_blocked: assert property (@(posedge ref_clk)
      disable iff (!rst_n) reg_rd && reg_addr == dfs_pkg::OFS_RDATA &&
      seq_busy |=> reg_rdata == 8'h0_000)
      else $error("array data visible during rewrite");
   c_erase: cover property (@(posedge ref_clk) a_er);
   c_write: cover property (@(posedge ref_clk)
      state_reg == dfs_pkg::DFS_WAIT_TRG ##1 state_reg == dfs_pkg::DFS_RUN);
   c_blank_err: cover property (@(posedge ref_clk)
      status_reg == dfs_pkg::DFS_ST_BLANKE);
   c_refused: cover property (@(posedge ref_clk) wr_hit_cmd && !enabled);
endmodule // dfs_seq
`default_nettype wire

// >>> verification/dfs_osc_model.sv
// Model of the high-speed on-chip oscillator beside the sequencer.
// Assumes osc_request follows the access-enable bit and seq_busy the engine.
`timescale 1ns/10ps
`default_nettype none
module dfs_osc_model (
   input  wire logic ref_clk,
   input  wire logic rst_n,
   input  wire logic osc_request,
   input  wire logic seq_busy,
   output logic      osc_running,
   output int        n_bad
);
   logic [1:0] start_reg;
   // Startup lag, so an engine started too early is caught
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         start_reg   <= 2'h0;
         osc_running <= 1'b0;
         n_bad       <= 0;
      end else begin
         if (!osc_request) begin
            start_reg <= 2'h0;
         end else if (start_reg != 2'h3) begin
            start_reg <= start_reg + 2'h1;
         end
         osc_running <= osc_request && (start_reg == 2'h3);
         if (seq_busy && !osc_running) begin
            n_bad <= n_bad + 1;
         end
      end
   end
endmodule // dfs_osc_model
`default_nettype wire

// >>> verification/data_flash_sequencer_tb_top.sv
// Testbench for the data flash sequencer: register-port driver,
// integer memory model and scripted command flows.
// Assumes dfs_seq on ref_clk with the oscillator model beside it.
`timescale 1ns/10ps
`default_nettype none
module data_flash_sequencer_tb_top;
   logic        ref_clk;
   logic        rst_n;
   logic [19:0] reg_addr;
   logic [7:0]  reg_wdata;
   logic        reg_wr;
   logic        reg_rd;
   logic [7:0]  reg_rdata;
   logic        seq_busy;
   logic        osc_request;
   logic        osc_running;
   int          n_bad;
   int          n_mismatch;
   int          checks;
   int          mem [0:2047];
   logic [31:0] seed;
   logic [7:0]  d;
   int          step;
   int          k;

   dfs_seq dut (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .seq_busy(seq_busy),
      .osc_request(osc_request));
   dfs_osc_model osc (.ref_clk(ref_clk), .rst_n(rst_n),
      .osc_request(osc_request), .seq_busy(seq_busy),
      .osc_running(osc_running), .n_bad(n_bad));

   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   function automatic logic [7:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[7:0];
   endfunction

   task automatic stop_test();
      $display("checks %0d n_mismatch %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // The #1 lets the edge's updates land before anyone samples
   task automatic wr(input logic [19:0] a, input logic [7:0] v);
      @(posedge ref_clk);
      reg_addr  <= a;
      reg_wdata <= v;
      reg_wr    <= 1'b1;
      @(posedge ref_clk);
      reg_wr    <= 1'b0;
      #1;
   endtask

   task automatic rd(input logic [19:0] a);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge ref_clk);
      reg_rd   <= 1'b0;
      #1 d = reg_rdata;
   endtask

   task automatic op(input logic [2:0] c, input int a, input int n,
                     input logic [7:0] v);
      wr(dfs_pkg::OFS_ADDR_LO, a[7:0]);
      wr(dfs_pkg::OFS_ADDR_HI, 8'(a >> 8));
      wr(dfs_pkg::OFS_LEN_LO, n[7:0]);
      wr(dfs_pkg::OFS_LEN_HI, 8'(n >> 8));
      wr(dfs_pkg::OFS_WDATA, v);
      wr(dfs_pkg::OFS_CMD, {5'h00, c});
   endtask

   task automatic poll();
      int i;
      for (i = 0; i < 20000; i++) begin
         rd(dfs_pkg::OFS_STATUS);
         if (d[2] === 1'b0) break;
      end
      if (i == 20000) begin
         n_mismatch++;
         $display("mismatch at %0t: sequencer never finished", $time);
         stop_test();
      end
   endtask

   // Engine waits after each byte but the last; only a status read moves it on
   task automatic wbytes(input int a, input int n);
      logic [7:0] v;
      v = rnd();
      mem[a] = v;
      op(dfs_pkg::DFS_CMD_WRITE, a, n, v);
      chk(8'(seq_busy), 8'h01);
      for (int j = 1; j < n; j++) begin
         repeat (2 * step + 6) @(posedge ref_clk);
         #1 chk(8'(seq_busy), 8'h01);
         v = rnd();
         mem[a + j] = v;
         wr(dfs_pkg::OFS_WDATA, v);
         rd(dfs_pkg::OFS_STATUS);
      end
      poll();
      chk(d, 8'(dfs_pkg::DFS_ST_OK));
   endtask

   task automatic rback(input int a, input int n);
      op(dfs_pkg::DFS_CMD_READ, a, n, 8'h00);
      for (int j = 0; j < n; j++) begin
         if (j > 0) wr(dfs_pkg::OFS_CMD, 8'(dfs_pkg::DFS_CMD_READ));
         rd(dfs_pkg::OFS_STATUS);
         chk(d, 8'(dfs_pkg::DFS_ST_OK));
         rd(dfs_pkg::OFS_RDATA);
         chk(d, 8'(mem[a + j]));
      end
   endtask

   task automatic run(input logic [2:0] c, input int a, input int n,
                      input logic [7:0] s);
      op(c, a, n, 8'h00);
      poll();
      chk(d, s);
   endtask

   initial begin
      n_mismatch = 0;
      checks     = 0;
      seed       = 32'h0000_8168;
      step       = 3;
      rst_n      = 1'b0;
      reg_addr   = 20'h0_0000;
      reg_wdata  = 8'h00;
      reg_wr     = 1'b0;
      reg_rd     = 1'b0;
      for (k = 0; k < 2048; k++) mem[k] = 255;
      repeat (20) @(posedge ref_clk);
      rst_n <= 1'b1;
      rd(dfs_pkg::OFS_ACCESS_CTRL);
      chk(d, 8'h00);
      rd(dfs_pkg::OFS_CPU_FREQ);
      chk(d, dfs_pkg::RST_CPU_FREQ);
      rd(20'hF_00C0);
      chk(d, 8'h00);
      op(dfs_pkg::DFS_CMD_ERASE, 0, 1, 8'h00);
      chk(8'(seq_busy), 8'h00);
      rd(dfs_pkg::OFS_STATUS);
      chk(d, 8'(dfs_pkg::DFS_ST_ERR));
      wr(dfs_pkg::OFS_ACCESS_CTRL, 8'hFF);
      rd(dfs_pkg::OFS_ACCESS_CTRL);
      chk(d, 8'h01);
      chk(8'(osc_request), 8'h01);
      for (k = 0; k < 20 && osc_running !== 1'b1; k++) begin
         @(posedge ref_clk);
         #1;
      end
      chk(8'(osc_running), 8'h01);
      wbytes(1024, 4);
      wbytes(2047, 1);
      rback(1024, 4);
      rback(2047, 1);
      op(dfs_pkg::DFS_CMD_BLANK, 1024, 1024, 8'h00);
      chk(8'(seq_busy), 8'h01);
      rd(dfs_pkg::OFS_RDATA);
      chk(d, 8'h00);
      poll();
      chk(d, 8'(dfs_pkg::DFS_ST_BLANKE));
      run(dfs_pkg::DFS_CMD_WRITE, 1024, 1, 8'(dfs_pkg::DFS_ST_ERR));
      run(dfs_pkg::DFS_CMD_VERIFY, 1024, 4, 8'(dfs_pkg::DFS_ST_OK));
      run(dfs_pkg::DFS_CMD_ERASE, 1451, 1, 8'(dfs_pkg::DFS_ST_OK));
      for (k = 1024; k < 2048; k++) mem[k] = 255;
      run(dfs_pkg::DFS_CMD_BLANK, 1024, 1024, 8'(dfs_pkg::DFS_ST_OK));
      rback(2047, 1);
      for (k = 0; k < 3; k++) begin
         run(dfs_pkg::DFS_CMD_BLANK, k == 2 ? 1023 : 0,
             k == 0 ? 0 : (k == 1 ? 1025 : 2),
             8'(dfs_pkg::DFS_ST_ERR));
      end
      run(dfs_pkg::DFS_CMD_WRITE, 1020, 8, 8'(dfs_pkg::DFS_ST_ERR));
      run(3'h6, 0, 1, 8'(dfs_pkg::DFS_ST_ERR));
      wr(dfs_pkg::OFS_MODE, 8'h01);
      wr(dfs_pkg::OFS_CPU_FREQ, 8'h50);
      rd(dfs_pkg::OFS_CPU_FREQ);
      chk(d, 8'h50);
      rd(dfs_pkg::OFS_MODE);
      chk(d, 8'h01);
      step = 12;
      wbytes(16, 3);
      rback(16, 3);
      chk(8'(n_bad), 8'h00);
      wr(dfs_pkg::OFS_ACCESS_CTRL, 8'h00);
      chk(8'(osc_request), 8'h00);
      op(dfs_pkg::DFS_CMD_READ, 16, 1, 8'h00);
      rd(dfs_pkg::OFS_STATUS);
      chk(d, 8'(dfs_pkg::DFS_ST_ERR));
      rd(dfs_pkg::OFS_RDATA);
      chk(d, 8'h00);
      @(posedge ref_clk);
      rst_n <= 1'b0;
      repeat (3) @(posedge ref_clk);
      rst_n <= 1'b1;
      rd(dfs_pkg::OFS_ACCESS_CTRL);
      chk(d, 8'h00);
      stop_test();
   end
endmodule // data_flash_sequencer_tb_top
`default_nettype wire
